/* File: logic/prc_pkg.sv */
/*
 * Package for the reset, power and status control block of a three-port cable phy.
 * Holds register indices, field positions, reset values, timing constants and carriers.
 * Assumes a single 50 MHz clock drives every user of these constants.
 */
package prc_pkg;
   // Clock rate.
   localparam int CLK_KHZ = 50000;
   // Register indices on the plain register port (4-bit address).
   localparam logic [3:0] REG_STATUS0 = 4'h0;
   localparam logic [3:0] REG_STATUS6 = 4'h6;
   localparam logic [3:0] REG_SELFID9 = 4'h9;
   localparam logic [3:0] REG_CTRL_A = 4'hA;
   localparam logic [3:0] REG_MODE_B = 4'hB;
   // Field positions.
   localparam int BIT_R0_CABLE_POWER = 7;
   localparam int BIT_R0_LONG_RESET = 6;
   localparam int BIT_R6_CABLE_POWER = 2;
   localparam int BIT_R6_DROP_FLAG = 1;
   localparam int BIT_R9_SHORT_REQ = 7;
   localparam int BIT_R9_CONTENDER = 3;
   localparam int BIT_R9_PCLASS_LO = 0;
   localparam int BIT_RA_LONG_REQ = 0;
   localparam int BIT_RA_REMOTE_SHORT = 1;
   localparam int BIT_RA_REMOTE_LONG = 2;
   localparam int BIT_RA_LINK_ON = 3;
   // Self-ID bit positions of the power class field.
   localparam int SELFID_PCLASS_LO = 21;
   // Reset values.
   localparam logic [7:0] REG_RESET_VALUE = 8'h00;
   // Reset durations in nanoseconds, as printed in microseconds.
   localparam int LONG_RESET_MIN_NS = 167000;
   localparam int LONG_RESET_MAX_NS = 250000;
   localparam int SHORT_RESET_MIN_NS = 1300;
   localparam int SHORT_RESET_MAX_NS = 80000;
   localparam int CLK_PERIOD_NS = 1000000 / CLK_KHZ;
   // Least times round up, longest round down; the chosen length is the least time.
   localparam int LONG_RESET_CYCLES = (LONG_RESET_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int SHORT_RESET_CYCLES = (SHORT_RESET_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int SHORT_RESET_MAX_CYCLES = SHORT_RESET_MAX_NS / CLK_PERIOD_NS;
   // Link power sense: a square wave of at least 500 kHz, period 2000 ns.
   localparam int LPS_MIN_KHZ = 500;
   localparam int LPS_TIMEOUT_CYCLES = CLK_KHZ / LPS_MIN_KHZ;
   // Power-down least hold time, 3.5 ms in microseconds.
   localparam int PD_HOLD_US = 3500;
   localparam int PD_HOLD_CYCLES = PD_HOLD_US * (CLK_KHZ / 1000);
   // Link clock and link-on output rates in kHz.
   localparam int LINK_CLK_KHZ = 49152;
   localparam int LINK_ON_KHZ = 6114;
   localparam int LINK_ON_HALF = CLK_KHZ / (2 * LINK_ON_KHZ);
   // Counter widths.
   localparam int CNT_W = 24;
   // Bus reset kinds.
   typedef enum logic [1:0] {PRC_RST_NONE, PRC_RST_LONG, PRC_RST_SHORT} prc_reset_kind_t;
   // Synchronised pin inputs.
   typedef struct packed {
      logic short_reset_mode_strap_n;
      logic factory_test_strap_a;
      logic cable_power_sense;
      logic link_power_sense;
      logic contender;
      logic [2:0] power_class_straps;
   } prc_pins_t;
endpackage : prc_pkg

/* File: logic/prc_control.sv */
/*
 * Reset, power and status control of a three-port cable phy: bus reset mode choice,
 * cable power monitoring, link power detection, power-down and strap-driven self-ID fields.
 * Assumes pins synchronous to clock or synchronised here, and a register port whose
 * read data stand one cycle after the read strobe.
 */
// Local design decisions: the register addresses and the strobed register port.
`timescale 1ns/10ps
module prc_control (
   // Clock and reset.
   input wire logic clock,
   input wire logic rst,
   input wire logic logic_reset_n,
   input wire logic power_down_input,
   // Register port.
   input wire logic [3:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_write,
   input wire logic reg_read,
   output logic [7:0] reg_rdata,
   // Straps and sense pins.
   input wire logic short_reset_mode_strap_n,
   input wire logic factory_test_strap_a,
   input wire logic cable_power_sense,
   input wire logic link_power_sense,
   input wire logic [2:0] power_class_straps,
   // Cable side.
   input wire logic [2:0] port_connected,
   input wire logic remote_short_reset,
   input wire logic remote_long_reset,
   input wire logic link_on_message,
   output logic bus_reset_active,
   output logic bus_reset_short,
   output logic cable_inactive_output,
   // Contender or wake pin, three signals.
   input wire logic contender_or_wake_in,
   output logic contender_or_wake_out,
   output logic contender_or_wake_oe_n,
   // Link side enables and clock.
   input wire logic link_clock_source,
   output logic link_side_clock_out,
   output logic link_outputs_enable,
   output logic link_powered,
   output logic [2:0] selfid_pclass,
   output logic selfid_contender
);
   // Internal reset: power-down pulls the logic reset low.
   logic core_rst;
   assign core_rst = rst | ~logic_reset_n | power_down_input;

   // Two-flop synchronisers for pin inputs.
   prc_pkg::prc_pins_t pins_raw, pins_s1, pins_s2;
   always_comb begin
      pins_raw = '{short_reset_mode_strap_n, factory_test_strap_a, cable_power_sense,
                   link_power_sense, contender_or_wake_in, power_class_straps};
   end
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         // Reset to the normal-use levels (mode straps high, power class straps low, cable power present).
         // This way no false power drop is flagged while the synchroniser fills.
         pins_s1 <= '{1'b1, 1'b1, 1'b1, 1'b0, 1'b0, 3'h0};
         pins_s2 <= '{1'b1, 1'b1, 1'b1, 1'b0, 1'b0, 3'h0};
      end else begin
         pins_s1 <= pins_raw;
         pins_s2 <= pins_s1;
      end
   end

   // Mode decode used by several processes.
   function automatic logic short_mode(input prc_pkg::prc_pins_t p);
      return p.factory_test_strap_a & ~p.short_reset_mode_strap_n;
   endfunction : short_mode
   logic mode_short;
   assign mode_short = short_mode(pins_s2);

   // Register write decodes.
   logic wr_r6, wr_r9, wr_ra;
   assign wr_r6 = reg_write && reg_addr == prc_pkg::REG_STATUS6;
   assign wr_r9 = reg_write && reg_addr == prc_pkg::REG_SELFID9;
   assign wr_ra = reg_write && reg_addr == prc_pkg::REG_CTRL_A;

   // Cable power state and drop flag.
   logic power_prev, drop_flag, next_power_prev, next_drop_flag, power_drop;
   always_comb begin
      power_drop = power_prev & ~pins_s2.cable_power_sense;
      next_power_prev = pins_s2.cable_power_sense;
      next_drop_flag = drop_flag;
      if (wr_r6 && !reg_wdata[prc_pkg::BIT_R6_DROP_FLAG]) begin
         next_drop_flag = 1'b0;
      end
      if (power_drop || !pins_s2.cable_power_sense) begin
         next_drop_flag = 1'b1;
      end
   end
   always_ff @(posedge clock or posedge core_rst) begin
      if (core_rst) begin
         power_prev <= 1'b0;
         drop_flag <= 1'b0;
      end else begin
         power_prev <= next_power_prev;
         drop_flag <= next_drop_flag;
      end
   end

   // Bus reset sequencer.
   prc_pkg::prc_reset_kind_t kind, next_kind;
   logic [prc_pkg::CNT_W-1:0] rst_cnt, next_rst_cnt;
   logic short_req, next_short_req, boot_reset, next_boot_reset;
   logic start_long, start_short;
   always_comb begin
      next_short_req = short_req;
      if (wr_r9 && reg_wdata[prc_pkg::BIT_R9_SHORT_REQ] && mode_short) begin
         next_short_req = 1'b1;
      end
      start_short = mode_short && (short_req || remote_short_reset);
      start_long = boot_reset || (wr_ra && reg_wdata[prc_pkg::BIT_RA_LONG_REQ]) || remote_long_reset
                   || (!mode_short && remote_short_reset);
      next_kind = kind;
      next_rst_cnt = rst_cnt;
      next_boot_reset = 1'b0;
      if (kind == prc_pkg::PRC_RST_NONE) begin
         if (start_long) begin
            next_kind = prc_pkg::PRC_RST_LONG;
            next_rst_cnt = prc_pkg::CNT_W'(prc_pkg::LONG_RESET_CYCLES - 1);
         end else if (start_short) begin
            next_kind = prc_pkg::PRC_RST_SHORT;
            next_rst_cnt = prc_pkg::CNT_W'(prc_pkg::SHORT_RESET_CYCLES - 1);
            next_short_req = 1'b0;
         end
      end else if (rst_cnt == '0) begin
         next_kind = prc_pkg::PRC_RST_NONE;
      end else begin
         next_rst_cnt = rst_cnt - 1'b1;
      end
   end
   always_ff @(posedge clock or posedge core_rst) begin
      if (core_rst) begin
         kind <= prc_pkg::PRC_RST_NONE;
         rst_cnt <= '0;
         short_req <= 1'b0;
         boot_reset <= 1'b1;
      end else begin
         kind <= next_kind;
         rst_cnt <= next_rst_cnt;
         short_req <= next_short_req;
         boot_reset <= next_boot_reset;
      end
   end
   assign bus_reset_active = kind != prc_pkg::PRC_RST_NONE;
   assign bus_reset_short = kind == prc_pkg::PRC_RST_SHORT;

   // Link power detection: a high sense level within the timeout means powered.
   logic lps_prev, next_lps_prev, lps_ok, next_lps_ok;
   logic [prc_pkg::CNT_W-1:0] lps_cnt, next_lps_cnt;
   always_comb begin
      next_lps_prev = pins_s2.link_power_sense;
      next_lps_cnt = lps_cnt;
      next_lps_ok = lps_ok;
      if (pins_s2.link_power_sense) begin
         next_lps_cnt = '0;
         next_lps_ok = 1'b1;
      end else if (lps_cnt >= prc_pkg::CNT_W'(prc_pkg::LPS_TIMEOUT_CYCLES)) begin
         next_lps_ok = 1'b0;
      end else begin
         next_lps_cnt = lps_cnt + 1'b1;
      end
   end
   always_ff @(posedge clock or posedge core_rst) begin
      if (core_rst) begin
         lps_prev <= 1'b0;
         lps_cnt <= '0;
         lps_ok <= 1'b0;
      end else begin
         lps_prev <= next_lps_prev;
         lps_cnt <= next_lps_cnt;
         lps_ok <= next_lps_ok;
      end
   end
   assign link_powered = lps_ok;
   assign link_outputs_enable = lps_ok & ~power_down_input;
   // The link clock comes from the transfer clock source, gated by link power and by power-down.
   assign link_side_clock_out = link_clock_source & link_outputs_enable;

   // Link-on tone generator and strap capture.
   logic link_on, next_link_on, tone, next_tone;
   logic [7:0] tone_cnt, next_tone_cnt;
   logic [2:0] pclass, next_pclass;
   logic contender, next_contender;
   always_comb begin
      next_link_on = link_on | link_on_message;
      next_tone = tone;
      next_tone_cnt = tone_cnt + 1'b1;
      if (tone_cnt == 8'(prc_pkg::LINK_ON_HALF - 1)) begin
         next_tone_cnt = '0;
         next_tone = ~tone & link_on;
      end
      if (wr_ra && reg_wdata[prc_pkg::BIT_RA_LINK_ON]) begin
         next_link_on = link_on_message; // A message in the same cycle wins.
      end
      next_pclass = pins_s2.power_class_straps;
      next_contender = link_on ? contender : pins_s2.contender;
   end
   always_ff @(posedge clock or posedge core_rst) begin
      if (core_rst) begin
         link_on <= 1'b0;
         tone <= 1'b0;
         tone_cnt <= '0;
         pclass <= '0;
         contender <= 1'b0;
      end else begin
         link_on <= next_link_on;
         tone <= next_tone;
         tone_cnt <= next_tone_cnt;
         pclass <= next_pclass;
         contender <= next_contender;
      end
   end
   assign contender_or_wake_out = tone;
   assign contender_or_wake_oe_n = ~link_on;
   assign selfid_pclass = pclass;
   assign selfid_contender = contender;

   // Cable-inactive output stays alive through power-down.
   assign cable_inactive_output = ~|port_connected;

   // Register read mux.
   logic [7:0] next_rdata;
   always_comb begin
      next_rdata = prc_pkg::REG_RESET_VALUE;
      if (reg_read) begin
         unique case (reg_addr)
            prc_pkg::REG_STATUS0: begin
               next_rdata[prc_pkg::BIT_R0_CABLE_POWER] = pins_s2.cable_power_sense;
               next_rdata[prc_pkg::BIT_R0_LONG_RESET] = kind == prc_pkg::PRC_RST_LONG;
            end
            prc_pkg::REG_STATUS6: begin
               next_rdata[prc_pkg::BIT_R6_CABLE_POWER] = pins_s2.cable_power_sense;
               next_rdata[prc_pkg::BIT_R6_DROP_FLAG] = drop_flag;
            end
            prc_pkg::REG_SELFID9: begin
               next_rdata[prc_pkg::BIT_R9_SHORT_REQ] = short_req;
               next_rdata[prc_pkg::BIT_R9_CONTENDER] = contender;
               next_rdata[prc_pkg::BIT_R9_PCLASS_LO +: 3] = pclass;
            end
            prc_pkg::REG_MODE_B: next_rdata = {5'h00, lps_ok, bus_reset_short, mode_short};
            default: next_rdata = prc_pkg::REG_RESET_VALUE;
         endcase
      end
   end
   always_ff @(posedge clock or posedge core_rst) begin
      if (core_rst) begin
         reg_rdata <= prc_pkg::REG_RESET_VALUE;
      end else begin
         reg_rdata <= next_rdata;
      end
   end

   // Length of the running bus reset, counted for the length checks below.
   // It restarts at zero between resets, so back-to-back resets are measured apart.
   logic [prc_pkg::CNT_W-1:0] reset_len, next_reset_len;
   always_comb begin
      next_reset_len = '0;
      if (bus_reset_active) begin
         next_reset_len = reset_len + 1'b1;
      end
   end
   always_ff @(posedge clock or posedge core_rst) begin
      if (core_rst) begin
         reset_len <= '0;
      end else begin
         reset_len <= next_reset_len;
      end
   end

   // Assertions.
   // A long reset stands for its first cycles once begun.
   a_long_reset_len: assert property (@(posedge clock) disable iff (core_rst)
      $rose(kind == prc_pkg::PRC_RST_LONG) |-> ##1 (kind == prc_pkg::PRC_RST_LONG) [*8])
      else $error("long reset too short");
   // A long reset ends inside its bounds.
   a_long_reset_max: assert property (@(posedge clock) disable iff (core_rst)
      $fell(kind == prc_pkg::PRC_RST_LONG) |-> reset_len >= prc_pkg::CNT_W'(prc_pkg::LONG_RESET_CYCLES)
         && reset_len <= prc_pkg::CNT_W'(prc_pkg::LONG_RESET_MAX_NS / prc_pkg::CLK_PERIOD_NS))
      else $error("long reset length wrong");
   // A short reset ends inside its bounds.
   a_short_reset_len: assert property (@(posedge clock) disable iff (core_rst)
      $fell(bus_reset_short) |-> reset_len >= prc_pkg::CNT_W'(prc_pkg::SHORT_RESET_CYCLES)
         && reset_len <= prc_pkg::CNT_W'(prc_pkg::SHORT_RESET_MAX_CYCLES))
      else $error("short reset length wrong");
   // Legacy mode never starts a short reset.
   a_legacy_no_short: assert property (@(posedge clock) disable iff (core_rst)
      !mode_short |-> ##1 !$rose(bus_reset_short))
      else $error("short reset in legacy mode");
   // A cable power drop sets the flag.
   a_drop_sets_flag: assert property (@(posedge clock) disable iff (core_rst)
      power_drop |=> drop_flag)
      else $error("drop flag not set");
   // The flag comes back while cable power stays low.
   a_flag_returns: assert property (@(posedge clock) disable iff (core_rst)
      !pins_s2.cable_power_sense |=> drop_flag)
      else $error("drop flag clear while power low");
   // The short request is gone once its reset has begun.
   a_short_req_clears: assert property (@(posedge clock) disable iff (core_rst)
      $rose(bus_reset_short) |-> !short_req)
      else $error("short request not cleared");
   // Every port free raises the cable-inactive output.
   a_cable_inactive: assert property (@(posedge clock) disable iff (rst)
      (port_connected == 3'h0) |-> cable_inactive_output)
      else $error("cable inactive wrong");
   // Any connected port pulls the cable-inactive output low.
   a_cable_active: assert property (@(posedge clock) disable iff (rst)
      (port_connected != 3'h0) |-> !cable_inactive_output)
      else $error("cable inactive high with a port connected");
   // An unpowered link sees no outputs and no clock.
   a_unpowered_link: assert property (@(posedge clock) disable iff (core_rst)
      !lps_ok |-> !link_outputs_enable && !link_side_clock_out)
      else $error("link outputs on while unpowered");
   // A high sense level marks the link powered in the next cycle.
   a_link_sense_seen: assert property (@(posedge clock) disable iff (core_rst)
      pins_s2.link_power_sense |=> link_powered)
      else $error("link power not seen");
   // Power-down leaves only the cable-inactive output alive.
   a_power_down_off: assert property (@(posedge clock) disable iff (rst)
      power_down_input |-> !link_outputs_enable && !link_side_clock_out && !bus_reset_active)
      else $error("link side alive in power-down");
   // Power-down keeps the internal state in reset.
   a_power_down_reset: assert property (@(posedge clock) disable iff (rst)
      power_down_input |-> !drop_flag && !short_req && !link_on && reg_rdata == prc_pkg::REG_RESET_VALUE)
      else $error("state not held in power-down");
   // Leaving the internal reset starts a long bus reset.
   a_boot_long_reset: assert property (@(posedge clock) disable iff (rst)
      $fell(core_rst) |=> bus_reset_active && !bus_reset_short)
      else $error("no long reset after logic reset");
   // A short reset request is never stored outside short mode.
   a_legacy_no_request: assert property (@(posedge clock) disable iff (core_rst)
      !mode_short |-> ##1 !$rose(short_req))
      else $error("short request stored in legacy mode");
   // A link-on message takes the contender pin over in the next cycle.
   a_link_on_drive: assert property (@(posedge clock) disable iff (core_rst)
      link_on_message |=> !contender_or_wake_oe_n)
      else $error("link-on not driven");
   // Both copies of the cable power bit, and the flag, follow their sources on a read.
   a_status0_power: assert property (@(posedge clock) disable iff (core_rst)
      reg_read && reg_addr == prc_pkg::REG_STATUS0
      |=> reg_rdata[prc_pkg::BIT_R0_CABLE_POWER] == $past(pins_s2.cable_power_sense))
      else $error("register 0 cable power wrong");
   a_status6_fields: assert property (@(posedge clock) disable iff (core_rst)
      reg_read && reg_addr == prc_pkg::REG_STATUS6
      |=> reg_rdata[prc_pkg::BIT_R6_CABLE_POWER] == $past(pins_s2.cable_power_sense)
         && reg_rdata[prc_pkg::BIT_R6_DROP_FLAG] == $past(drop_flag))
      else $error("register 6 fields wrong");
endmodule : prc_control

/* File: tb/prc_link_model.sv */
/*
 * Behavioural link layer controller as the phy sees it: it drives the link power sense pin.
 * Assumes the 50 MHz bench clock and a bench that says whether the link has power.
 */
`timescale 1ns/10ps
module prc_link_model (
   // Clock.
   input wire logic clock,
   // Power state chosen by the bench.
   input wire logic powered,
   // Pin towards the phy.
   output logic link_power_sense
);
   logic [4:0] div = 5'h00;

   initial link_power_sense = 1'h0;

   // A powered link toggles the pin every 20 cycles, 1.25 MHz; an unpowered one leaves it low.
   always @(posedge clock) begin
      if (!powered) begin
         div <= 5'h00;
         link_power_sense <= 1'h0;
      end else begin
         div <= (div == 5'h13) ? 5'h00 : div + 5'h01;
         if (div == 5'h13) begin
            link_power_sense <= ~link_power_sense;
         end
      end
   end
endmodule : prc_link_model

/* File: tb/tb_top.sv */
/*
 * Self-checking bench of the reset, power and status control block.
 * Assumes the block's register port answers one cycle after the read strobe.
 */
`timescale 1ns/10ps
module tb_top;
   logic clock = 1'h0, rst = 1'h1, logic_reset_n = 1'h1, power_down_input = 1'h0;
   logic [3:0] reg_addr = 4'h0;
   logic [7:0] reg_wdata = 8'h00, reg_rdata;
   logic reg_write = 1'h0, reg_read = 1'h0, short_reset_mode_strap_n = 1'h1, factory_test_strap_a = 1'h1;
   logic cable_power_sense = 1'h1, link_power_sense, powered = 1'h1, link_clock_source = 1'h0;
   logic [2:0] power_class_straps = 3'h5, port_connected = 3'h1, selfid_pclass;
   logic remote_short_reset = 1'h0, remote_long_reset = 1'h0, link_on_message = 1'h0, cont = 1'h1;
   logic bus_reset_active, bus_reset_short, cable_inactive_output, contender_or_wake_in;
   logic contender_or_wake_out, contender_or_wake_oe_n, link_side_clock_out, link_outputs_enable;
   logic link_powered, selfid_contender, rd_d = 1'h0, prev;
   logic [31:0] seed = 32'hB788;
   logic [7:0] exp_q[$];
   int fail_count = 0, num_checks = 0, cyc = 0, t;

   // Clocks: the block's own clock and an unrelated source for the link clock.
   always #10 clock = ~clock;
   always #10.17 link_clock_source = ~link_clock_source;
   // The contender pin is strapped through a resistor, so the block's drive wins when enabled.
   assign contender_or_wake_in = contender_or_wake_oe_n ? cont : contender_or_wake_out;

   prc_control prc_control_i (.clock, .rst, .logic_reset_n, .power_down_input, .reg_addr, .reg_wdata,
      .reg_write, .reg_read, .reg_rdata, .short_reset_mode_strap_n, .factory_test_strap_a,
      .cable_power_sense, .link_power_sense, .power_class_straps, .port_connected, .remote_short_reset,
      .remote_long_reset, .link_on_message, .bus_reset_active, .bus_reset_short, .cable_inactive_output,
      .contender_or_wake_in, .contender_or_wake_out, .contender_or_wake_oe_n, .link_clock_source,
      .link_side_clock_out, .link_outputs_enable, .link_powered, .selfid_pclass, .selfid_contender);
   prc_link_model prc_link_model_i (.clock(clock), .powered(powered), .link_power_sense(link_power_sense));

   function automatic logic [31:0] xs(input logic [31:0] v);
      logic [31:0] x;
      x = v ^ (v << 13);
      x = x ^ (x >> 17);
      return x ^ (x << 5);
   endfunction : xs

   task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
      num_checks++;
      if (got !== exp) begin
         fail_count++;
         $display("Error %s expected %h seen %h", what, exp, got);
      end
   endtask : check

   task automatic check_len(input string what, input int n, input int lo, input int hi);
      num_checks++;
      if (n < lo || n > hi) begin
         fail_count++;
         $display("Error %s expected %0d to %0d seen %0d", what, lo, hi, n);
      end
   endtask : check_len

   task automatic tick(input int k);
      repeat (k) @(posedge clock);
   endtask : tick

   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge clock);
      reg_addr <= a;
      reg_wdata <= d;
      reg_write <= 1'h1;
      @(posedge clock);
      reg_write <= 1'h0;
   endtask : wr

   task automatic rd(input logic [3:0] a, input logic [7:0] exp);
      exp_q.push_back(exp);
      @(posedge clock);
      reg_addr <= a;
      reg_read <= 1'h1;
      @(posedge clock);
      reg_read <= 1'h0;
      @(posedge clock);
   endtask : rd

   // Waits for a bus reset, checks its kind, then measures how long it stands.
   task automatic burst(input logic exp_short, input int lo, input int hi);
      int n;
      n = 0;
      while (bus_reset_active !== 1'h1 && n < 20) begin
         @(negedge clock);
         n++;
      end
      check("bus_reset_short", {7'h00, exp_short}, {7'h00, bus_reset_short});
      n = 0;
      while (bus_reset_active === 1'h1 && n < 13000) begin
         @(negedge clock);
         n++;
      end
      check_len("bus reset length", n, lo, hi);
   endtask : burst

   task automatic final_report;
      $display("checks %0d mismatches %0d", num_checks, fail_count);
      if (fail_count == 0 && num_checks > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask : final_report

   // Read data stand in the cycle after the strobe; the oldest note is compared then.
   always @(posedge clock) rd_d <= reg_read;
   always @(negedge clock) begin
      if (rd_d) begin
         check("reg_rdata", exp_q.pop_front(), reg_rdata);
      end
   end

   // Cuts a hung run short.
   always @(posedge clock) begin
      cyc++;
      if (cyc == 80000) begin
         fail_count++;
         final_report();
      end
   end

   // Main sequence of scenarios.
   initial begin
      tick(8);
      rst <= 1'h0;
      burst(1'h0, 8350, 12500);
      rd(prc_pkg::REG_STATUS0, 8'h80);
      rd(prc_pkg::REG_STATUS6, 8'h04);
      rd(4'h3, 8'h00);
      cable_power_sense <= 1'h0;
      tick(4);
      rd(prc_pkg::REG_STATUS0, 8'h00);
      rd(prc_pkg::REG_STATUS6, 8'h02);
      wr(prc_pkg::REG_STATUS6, 8'h00);
      rd(prc_pkg::REG_STATUS6, 8'h02);
      cable_power_sense <= 1'h1;
      tick(4);
      rd(prc_pkg::REG_STATUS6, 8'h06);
      wr(prc_pkg::REG_STATUS6, 8'h00);
      rd(prc_pkg::REG_STATUS6, 8'h04);
      wr(prc_pkg::REG_SELFID9, 8'h80);
      tick(4);
      check("bus_reset_active", 8'h00, {7'h00, bus_reset_active});
      remote_short_reset <= 1'h1;
      @(posedge clock);
      remote_short_reset <= 1'h0;
      burst(1'h0, 8350, 12500);
      for (int i = 0; i < 4; i++) begin
         short_reset_mode_strap_n <= i[1];
         factory_test_strap_a <= i[0];
         tick(4);
         rd(prc_pkg::REG_MODE_B, {7'h02, i == 1});
      end
      short_reset_mode_strap_n <= 1'h0;
      factory_test_strap_a <= 1'h1;
      tick(6);
      check("bus_reset_active", 8'h00, {7'h00, bus_reset_active});
      for (int i = 0; i < 3; i++) begin
         seed = xs(seed);
         power_class_straps <= seed[2:0];
         cont <= seed[3];
         port_connected <= seed[6:4];
         tick(4);
         check("selfid_pclass", {5'h00, seed[2:0]}, {5'h00, selfid_pclass});
         check("selfid_contender", {7'h00, seed[3]}, {7'h00, selfid_contender});
         check("cable_inactive_output", {7'h00, seed[6:4] == 3'h0}, {7'h00, cable_inactive_output});
      end
      wr(prc_pkg::REG_SELFID9, 8'h80);
      burst(1'h1, 65, 4000);
      rd(prc_pkg::REG_SELFID9, {4'h0, seed[3:0]});
      remote_short_reset <= 1'h1;
      @(posedge clock);
      remote_short_reset <= 1'h0;
      burst(1'h1, 65, 4000);
      remote_long_reset <= 1'h1;
      @(posedge clock);
      remote_long_reset <= 1'h0;
      burst(1'h0, 8350, 12500);
      wr(prc_pkg::REG_CTRL_A, 8'h01);
      burst(1'h0, 8350, 12500);
      link_on_message <= 1'h1;
      @(posedge clock);
      link_on_message <= 1'h0;
      tick(3);
      check("contender_or_wake_oe_n", 8'h00, {7'h00, contender_or_wake_oe_n});
      t = 0;
      prev = contender_or_wake_out;
      repeat (32) begin
         @(posedge clock);
         t += (contender_or_wake_out !== prev);
         prev = contender_or_wake_out;
      end
      check("link-on toggles", 8'h08, t[7:0]);
      wr(prc_pkg::REG_CTRL_A, 8'h08);
      tick(2);
      check("contender_or_wake_oe_n", 8'h01, {7'h00, contender_or_wake_oe_n});
      @(posedge link_clock_source);
      #1;
      check("link_side_clock_out", 8'h01, {7'h00, link_side_clock_out});
      powered <= 1'h0;
      tick(150);
      check("link_outputs_enable", 8'h00, {7'h00, link_outputs_enable});
      check("link_side_clock_out", 8'h00, {7'h00, link_side_clock_out});
      rd(prc_pkg::REG_MODE_B, 8'h01);
      powered <= 1'h1;
      tick(50);
      check("link_powered", 8'h01, {7'h00, link_powered});
      cable_power_sense <= 1'h0;
      tick(4);
      cable_power_sense <= 1'h1;
      port_connected <= 3'h0;
      power_down_input <= 1'h1;
      tick(10);
      check("link_outputs_enable", 8'h00, {7'h00, link_outputs_enable});
      check("cable_inactive_output", 8'h01, {7'h00, cable_inactive_output});
      port_connected <= 3'h2;
      tick(2);
      check("cable_inactive_output", 8'h00, {7'h00, cable_inactive_output});
      rd(prc_pkg::REG_STATUS6, 8'h00);
      power_down_input <= 1'h0;
      burst(1'h0, 8350, 12500);
      rd(prc_pkg::REG_STATUS6, 8'h04);
      logic_reset_n <= 1'h0;
      tick(5);
      logic_reset_n <= 1'h1;
      burst(1'h0, 8350, 12500);
      final_report();
   end
endmodule : tb_top
